// *** core/bmx_regs.svh ***
// Constants of the bus matrix: port numbering, address map, access map.
// Assumes a single master clock and word-aligned 32-bit addresses.
// Overview of operation
// - Five masters each run concurrently when targeting different available slaves.
// - Every master has its own decoder; all decoders share one address map.
// - Ten slaves, each with its own arbiter; policy selectable per slave.
// - Masters numbered: 0 instr/data, 1 system, 2 periph DMA, 3 USB DMA, 4 DMA.
// - Slaves numbered 0 SRAM0 through 9 high-speed bridge in documented order.
// - Paths not allowed in the access map are not wired.
// - USB DMA master cannot reach either peripheral bridge.
// - Only the system bus reaches the USB dual-port RAM.
// - NAND RAM and external bus reachable from masters 1 to 4 only.
// - Low-speed bridge reachable only from system bus and peripheral DMA.
// - SPI, serial controller, card interface on high-speed bridge; others low-speed.
// - Both bridges accept accesses concurrently, same master clock.
`ifndef BMX_REGS_SVH
`define BMX_REGS_SVH
`define BMX_NUM_MST      5
`define BMX_NUM_SLV      10
`define BMX_M_IDBUS      0
`define BMX_M_SYSBUS     1
`define BMX_M_PDMA       2
`define BMX_M_USBDMA     3
`define BMX_M_DMAC       4
`define BMX_S_SRAM0      0
`define BMX_S_SRAM1      1
`define BMX_S_ROM        2
`define BMX_S_FLASH0     3
`define BMX_S_FLASH1     4
`define BMX_S_USBDPR     5
`define BMX_S_NANDRAM    6
`define BMX_S_EBI        7
`define BMX_S_LSBRIDGE   8
`define BMX_S_HSBRIDGE   9
// Access map, one row per slave, bit m set when master m is wired
`define BMX_MAP_SRAM0    5'h1e
`define BMX_MAP_SRAM1    5'h1e
`define BMX_MAP_ROM      5'h1d
`define BMX_MAP_FLASH0   5'h01
`define BMX_MAP_FLASH1   5'h01
`define BMX_MAP_USBDPR   5'h02
`define BMX_MAP_NANDRAM  5'h1e
`define BMX_MAP_EBI      5'h1e
`define BMX_MAP_LSBRIDGE 5'h06
`define BMX_MAP_HSBRIDGE 5'h16
// Address map: base and mask per slave (region = addr & mask == base)
`define BMX_BASE_SRAM0   32'h2000_0000
`define BMX_BASE_SRAM1   32'h2008_0000
`define BMX_BASE_NANDRAM 32'h2010_0000
`define BMX_BASE_ROM     32'h0018_0000
`define BMX_BASE_FLASH0  32'h0008_0000
`define BMX_BASE_FLASH1  32'h0010_0000
`define BMX_BASE_USBDPR  32'h2018_0000
`define BMX_BASE_EBI     32'h6000_0000
`define BMX_BASE_HSBRDG  32'h4000_0000
`define BMX_BASE_LSBRDG  32'h400e_0000
`define BMX_MASK_512K    32'hfff8_0000
`define BMX_MASK_256M    32'hf000_0000
`define BMX_MASK_HSBRDG  32'hfff8_0000
`define BMX_MASK_LSBRDG  32'hfffe_0000
`endif

// *** core/bmx_pkg.sv ***
// Types of the bus matrix: request and response carriers, arbiter policy.
// Assumes the constants header is on the include path.
package bmx_pkg;
  `include "bmx_regs.svh"
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bmx_req_s;
  typedef struct packed {
    logic        ready;
    logic        err;
    logic [31:0] rdata;
  } bmx_rsp_s;
  typedef enum logic [0:0] {
    BMX_ARB_RR    = 1'b0,
    BMX_ARB_FIXED = 1'b1
  } bmx_arb_e;
  typedef logic [`BMX_NUM_MST-1:0] bmx_mvec_t;
  typedef logic [`BMX_NUM_SLV-1:0] bmx_svec_t;
endpackage

// *** core/bmx_matrix.sv ***
// Five-master, ten-slave bus matrix with per-slave arbiters.
// Assumes masters hold a request until ready; slaves answer with ready.
`timescale 1ns/10ps
`include "bmx_regs.svh"
module bmx_matrix
  import bmx_pkg::*;
#(
  parameter bmx_svec_t ARB_FIXED = '0
) (
  // Clock and reset
  input  wire logic     mclk,
  input  wire logic     srst,
  // Master side
  input  wire bmx_req_s m_req [`BMX_NUM_MST],
  output bmx_rsp_s      m_rsp [`BMX_NUM_MST],
  // Slave side
  output bmx_req_s      s_req [`BMX_NUM_SLV],
  input  wire bmx_rsp_s s_rsp [`BMX_NUM_SLV]
);

  // Masked compare of one address window
  function automatic logic in_region(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] mask);
    return (a & mask) == base;
  endfunction

  // Shared address decode, one instance per master
  function automatic bmx_svec_t dec_addr(input logic [31:0] a);
    bmx_svec_t h;
    h = '0;
    h[`BMX_S_SRAM0]    = in_region(a, `BMX_BASE_SRAM0, `BMX_MASK_512K);
    h[`BMX_S_SRAM1]    = in_region(a, `BMX_BASE_SRAM1, `BMX_MASK_512K);
    h[`BMX_S_NANDRAM]  = in_region(a, `BMX_BASE_NANDRAM, `BMX_MASK_512K);
    h[`BMX_S_USBDPR]   = in_region(a, `BMX_BASE_USBDPR, `BMX_MASK_512K);
    h[`BMX_S_ROM]      = in_region(a, `BMX_BASE_ROM, `BMX_MASK_512K);
    h[`BMX_S_FLASH0]   = in_region(a, `BMX_BASE_FLASH0, `BMX_MASK_512K);
    h[`BMX_S_FLASH1]   = in_region(a, `BMX_BASE_FLASH1, `BMX_MASK_512K);
    h[`BMX_S_EBI]      = in_region(a, `BMX_BASE_EBI, `BMX_MASK_256M);
    h[`BMX_S_LSBRIDGE] = in_region(a, `BMX_BASE_LSBRDG, `BMX_MASK_LSBRDG);
    h[`BMX_S_HSBRIDGE] = in_region(a, `BMX_BASE_HSBRDG, `BMX_MASK_HSBRDG) &&
                         !h[`BMX_S_LSBRIDGE];
    return h;
  endfunction

  // Wiring per slave
  localparam bmx_mvec_t WIRED [`BMX_NUM_SLV] = '{
    `BMX_MAP_SRAM0,
    `BMX_MAP_SRAM1,
    `BMX_MAP_ROM,
    `BMX_MAP_FLASH0,
    `BMX_MAP_FLASH1,
    `BMX_MAP_USBDPR,
    `BMX_MAP_NANDRAM,
    `BMX_MAP_EBI,
    `BMX_MAP_LSBRIDGE,
    `BMX_MAP_HSBRIDGE
  };

  // Decoded target reachable over a wired path
  function automatic logic routed(input bmx_svec_t h, input int m, input int s);
    return h[s] && WIRED[s][m];
  endfunction

  // Round-robin pick starting after last grant
  function automatic bmx_mvec_t pick_rr(input bmx_mvec_t r, input logic [2:0] last);
    bmx_mvec_t g;
    logic [2:0] idx;
    g = '0;
    for (int k = 1; k <= `BMX_NUM_MST; k++) begin
      idx = 3'((int'(last) + k) % `BMX_NUM_MST);
      if (r[idx] && g == '0) begin
        g[idx] = 1'b1;
      end
    end
    return g;
  endfunction

  // Fixed priority, lowest master number wins
  function automatic bmx_mvec_t pick_fixed(input bmx_mvec_t r);
    bmx_mvec_t g;
    g = '0;
    for (int k = 0; k < `BMX_NUM_MST; k++) begin
      if (r[k] && g == '0) begin
        g[k] = 1'b1;
      end
    end
    return g;
  endfunction

  function automatic logic [2:0] enc(input bmx_mvec_t g);
    logic [2:0] e;
    e = '0;
    for (int k = 0; k < `BMX_NUM_MST; k++) begin
      if (g[k]) begin
        e = 3'(k);
      end
    end
    return e;
  endfunction

  bmx_svec_t  hit      [`BMX_NUM_MST];
  logic       bad      [`BMX_NUM_MST];
  bmx_mvec_t  sreq     [`BMX_NUM_SLV];
  bmx_mvec_t  grant    [`BMX_NUM_SLV];
  bmx_mvec_t  own_reg  [`BMX_NUM_SLV];
  logic [2:0] last_reg [`BMX_NUM_SLV];
  logic       err_reg  [`BMX_NUM_MST];
  logic       done     [`BMX_NUM_SLV];

  // Per-master decode
  always_comb begin
    for (int m = 0; m < `BMX_NUM_MST; m++) begin
      hit[m] = dec_addr(m_req[m].addr);
    end
  end

  // Unmapped or unwired target flags a bus error
  always_comb begin
    for (int m = 0; m < `BMX_NUM_MST; m++) begin
      bad[m] = m_req[m].valid && (hit[m] == '0);
      for (int s = 0; s < `BMX_NUM_SLV; s++) begin
        if (hit[m][s] && !routed(hit[m], m, s)) begin
          bad[m] = m_req[m].valid;
        end
      end
    end
  end

  // Requests gathered per slave, unwired paths masked out
  always_comb begin
    for (int s = 0; s < `BMX_NUM_SLV; s++) begin
      for (int m = 0; m < `BMX_NUM_MST; m++) begin
        sreq[s][m] = m_req[m].valid && routed(hit[m], m, s);
      end
    end
  end

  // Independent arbiter per slave, owner held until slave ready
  always_comb begin
    for (int s = 0; s < `BMX_NUM_SLV; s++) begin
      if ((own_reg[s] & sreq[s]) != '0) begin
        grant[s] = own_reg[s];
      end else if (ARB_FIXED[s]) begin
        grant[s] = pick_fixed(sreq[s]);
      end else begin
        grant[s] = pick_rr(sreq[s], last_reg[s]);
      end
    end
  end

  // Transfer on a slave ends with ready to a granted master
  always_comb begin
    for (int s = 0; s < `BMX_NUM_SLV; s++) begin
      done[s] = (grant[s] != '0) && s_rsp[s].ready;
    end
  end

  // Owner held until the slave answers
  always_ff @(posedge mclk) begin
    for (int s = 0; s < `BMX_NUM_SLV; s++) begin
      if (srst) begin
        own_reg[s] <= '0;
      end else if (done[s]) begin
        own_reg[s] <= '0;
      end else begin
        own_reg[s] <= grant[s];
      end
    end
  end

  // Round-robin pointer follows each completed grant
  always_ff @(posedge mclk) begin
    for (int s = 0; s < `BMX_NUM_SLV; s++) begin
      if (srst) begin
        last_reg[s] <= '0;
      end else if (done[s]) begin
        last_reg[s] <= enc(grant[s]);
      end
    end
  end

  // Slave muxes; each bridge muxed on its own
  always_comb begin
    for (int s = 0; s < `BMX_NUM_SLV; s++) begin
      s_req[s] = '0;
      for (int m = 0; m < `BMX_NUM_MST; m++) begin
        if (grant[s][m]) begin
          s_req[s] = m_req[m];
        end
      end
    end
  end

  // Error response: one wait cycle then ready with err
  always_ff @(posedge mclk) begin
    for (int m = 0; m < `BMX_NUM_MST; m++) begin
      if (srst) begin
        err_reg[m] <= 1'b0;
      end else begin
        err_reg[m] <= bad[m] && !err_reg[m];
      end
    end
  end

  // Master response muxes
  always_comb begin
    for (int m = 0; m < `BMX_NUM_MST; m++) begin
      m_rsp[m] = '0;
      if (err_reg[m]) begin
        m_rsp[m].ready = 1'b1;
        m_rsp[m].err   = 1'b1;
      end
      for (int s = 0; s < `BMX_NUM_SLV; s++) begin
        if (grant[s][m]) begin
          m_rsp[m] = s_rsp[s];
        end
      end
    end
  end

endmodule

// *** sim/bmx_sva.sv ***
// Port checker of the bus matrix.
// Assumes it is bound to bmx_matrix.
`timescale 1ns/10ps
module bmx_sva
  import bmx_pkg::*;
(
  // Clock and reset
  input wire logic     mclk,
  input wire logic     srst,
  // Buses
  input wire bmx_req_s m_req [5],
  input wire bmx_rsp_s m_rsp [5],
  input wire bmx_req_s s_req [10],
  input wire bmx_rsp_s s_rsp [10]
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  dpr_sys_only_a: assert property (
    s_req[5].valid |-> s_req[5] == m_req[1]) else $error("dpr path");
  flash_id_only_a: assert property (
    s_req[3].valid |-> s_req[3] == m_req[0]) else $error("flash path");
  ls_bridge_src_a: assert property (
    s_req[8].valid |-> s_req[8] == m_req[1] || s_req[8] == m_req[2]) else $error("ls path");
  usb_bridge_err_a: assert property (
    m_req[3].valid && m_req[3].addr[31:28] == 4'h4 && !m_rsp[3].ready
    |=> m_rsp[3].ready && m_rsp[3].err) else $error("usb bridge");
  id_low_err_a: assert property (
    m_req[0].valid && m_req[0].addr[31:28] == 4'h2 && !m_rsp[0].ready
    |=> m_rsp[0].ready && m_rsp[0].err) else $error("id error");
  dpr_grant_a: assert property (
    m_req[1].valid && m_req[1].addr[31:19] == 13'h0403 |-> s_req[5] == m_req[1])
    else $error("dpr grant");
  flash_grant_a: assert property (
    m_req[0].valid && m_req[0].addr[31:19] == 13'h0001 |-> s_req[3] == m_req[0])
    else $error("flash grant");
  grant_hold_a: assert property (
    s_req[1].valid && !s_rsp[1].ready |=> $stable(s_req[1])) else $error("grant hold");
  cover property (s_req[8].valid && s_req[9].valid);
  cover property (s_req[3].valid && s_req[5].valid);
  cover property (m_rsp[3].err);
endmodule
bind bmx_matrix bmx_sva chk (.mclk(mclk), .srst(srst), .m_req(m_req), .m_rsp(m_rsp),
  .s_req(s_req), .s_rsp(s_rsp));

// *** sim/bmx_slv_model.sv ***
// Slave model: answers after LAT cycles with the address xor its number.
// Assumes the matrix holds a request until ready.
`timescale 1ns/10ps
module bmx_slv_model
  import bmx_pkg::*;
#(
  parameter int LAT = 0,
  parameter int IDX = 0
) (
  // Clock
  input  wire logic     mclk,
  // Request and answer
  input  wire bmx_req_s req,
  output bmx_rsp_s      rsp
);
  int   cnt = 0;
  logic rdy;
  assign rdy = req.valid && cnt >= LAT;
  // Idle data is inverted, never the last word
  assign rsp = {rdy, 1'b0, rdy ? req.addr ^ 32'(IDX) : ~req.addr};
  always @(posedge mclk) cnt <= (req.valid && !rdy) ? cnt + 1 : 0;
endmodule

// *** sim/bus_matrix_access_map_tb.sv ***
// Fixed and random concurrent rounds over the bus matrix.
// Assumes slave models answer with the address xor the slave number.
`timescale 1ns/10ps
module bus_matrix_access_map_tb;
  import bmx_pkg::*;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  bmx_req_s    m_req [5];
  bmx_rsp_s    m_rsp [5];
  bmx_req_s    s_req [10];
  bmx_rsp_s    s_rsp [10];
  int          num_errors = 0;
  int          n_compared = 0;
  int          seed = 32'h0000_ca05;
  int          pick [5];
  logic [31:0] base [11] = '{32'h2000_0000, 32'h2008_0000, 32'h0018_0000, 32'h0008_0000,
    32'h0010_0000, 32'h2018_0000, 32'h2010_0000, 32'h6000_0000, 32'h400e_0000,
    32'h4000_0000, 32'ha000_0000};
  logic [4:0]  amap [11] = '{5'h1e, 5'h1e, 5'h1d, 5'h01, 5'h01, 5'h02, 5'h1e, 5'h1e,
    5'h06, 5'h16, 5'h00};
  always #50 mclk = ~mclk;
  bmx_matrix #(.ARB_FIXED(10'h0c0)) dut (.mclk(mclk), .srst(srst), .m_req(m_req),
    .m_rsp(m_rsp), .s_req(s_req), .s_rsp(s_rsp));
  for (genvar s = 0; s < 10; s++) begin : g_slv
    bmx_slv_model #(.LAT(s % 3), .IDX(s)) slv (.mclk(mclk), .req(s_req[s]), .rsp(s_rsp[s]));
  end
  function automatic logic [33:0] exp_word(int s, int m, logic [31:0] a);
    return amap[s][m] ? {2'b10, a ^ 32'(s)} : {2'b11, 32'h0000_0000};
  endfunction
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input int m, input int s);
    logic [31:0] a;
    int          n;
    a = base[s] + ($random(seed) & 32'h0001_fffc);
    m_req[m] = '{1'b1, a[2], a, $random(seed)};
    n = 0;
    #10;
    while (m_rsp[m].ready !== 1'b1 && n < 40) begin
      @(negedge mclk) #10;
      n++;
    end
    check({m_rsp[m].ready, m_rsp[m].err, amap[s][m] ? m_rsp[m].rdata : 32'h0}, exp_word(s, m, a));
    @(negedge mclk) m_req[m] = '0;
  endtask
  task automatic round(input int r [5]);
    foreach (r[m]) begin
      automatic int k = m;
      fork
        xfer(k, r[k]);
      join_none
    end
    wait fork;
    @(negedge mclk);
  endtask
  task automatic summarize();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    foreach (m_req[m]) m_req[m] = '0;
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    round('{3, 5, 8, 9, 2});
    round('{5, 9, 8, 8, 10});
    round('{0, 0, 0, 0, 0});
    repeat (150) begin
      foreach (pick[m]) pick[m] = $unsigned($random(seed)) % 11;
      round(pick);
    end
    summarize();
  end
  initial begin
    #4_000_000;
    num_errors++;
    summarize();
  end
endmodule
